// ---- hdl/ser_pkg.sv ----
// Purpose: Shared constants for the status and event reporting block
// Assumes: One instrument clock; commands arrive decoded from a parser
// Notes:   Command codes are the parser's, bit positions the status map
package ser_pkg;

  // Command codes presented on CMD_CODE with CMD_STB
  localparam logic [3:0] CMD_ESR_QUERY   = 4'h0;
  localparam logic [3:0] CMD_ESE_SET     = 4'h1;
  localparam logic [3:0] CMD_ESE_QUERY   = 4'h2;
  localparam logic [3:0] CMD_QUES_COND_Q = 4'h3;
  localparam logic [3:0] CMD_QUES_EVEN_Q = 4'h4;
  localparam logic [3:0] CMD_OPER_COND_Q = 4'h5;
  localparam logic [3:0] CMD_OPER_EVEN_Q = 4'h6;
  localparam logic [3:0] CMD_STB_QUERY   = 4'h7;
  localparam logic [3:0] CMD_SRE_SET     = 4'h8;
  localparam logic [3:0] CMD_SRE_QUERY   = 4'h9;
  localparam logic [3:0] CMD_OPC         = 4'hA;

  // Event status flag positions
  localparam int ESR_OPC_BIT   = 0;
  localparam int ESR_UNUSED    = 1;
  localparam int ESR_QERR_BIT  = 2;
  localparam int ESR_DDE_BIT   = 3;
  localparam int ESR_EXE_BIT   = 4;
  localparam int ESR_CME_BIT   = 5;
  localparam int ESR_URQ_BIT   = 6;
  localparam int ESR_PON_BIT   = 7;

  // Status byte positions
  localparam int STB_ERRQ_BIT  = 2;
  localparam int STB_QUES_BIT  = 3;
  localparam int STB_MAV_BIT   = 4;
  localparam int STB_ESB_BIT   = 5;
  localparam int STB_MSS_BIT   = 6;
  localparam int STB_OPER_BIT  = 7;

  // Operation activity flag positions
  localparam int OPER_CAL_BIT  = 0;

  // Status byte bits that may raise a service request
  localparam logic [7:0] SRQ_SRC_MASK = 8'h34;
  // Enable bit ignored in the service request enable mask
  localparam logic [7:0] SRE_WR_MASK  = 8'hBF;

  // Reset values
  localparam logic [7:0]  ESR_RST  = 8'h00;
  localparam logic [7:0]  ESE_RST  = 8'h00;
  localparam logic [7:0]  SRE_RST  = 8'h00;
  localparam logic [15:0] OPER_RST = 16'h0000;
  localparam logic [15:0] QUES_VAL = 16'h0000;

  // Decimal response shape
  localparam int BIN_W = 16;
  localparam int DEC_D = 5;

endpackage : ser_pkg

// ---- hdl/ser_bin2dec.sv ----
// Purpose: Serial binary to packed decimal converter for query answers
// Assumes: start is one cycle, ignored while busy
// Notes:   One shift per clock, so an answer takes W cycles plus one
`timescale 1ns/1ps
module ser_bin2dec
  import ser_pkg::*;
#(
  parameter int W = BIN_W,
  parameter int D = DEC_D
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Request
  input  wire logic         start,
  input  wire logic [W-1:0] bin,
  // Result
  output logic              busy,
  output logic              done,
  output logic [D*4-1:0]    dec
);

  typedef enum logic {S_IDLE, S_RUN} ser_cv_state_t;

  ser_cv_state_t     state_reg;   // Converter state
  logic [D*4-1:0]    bcd_reg;     // Decimal digits being built
  logic [W-1:0]      bin_reg;     // Binary bits left to shift
  logic [5:0]        cnt_reg;     // Shifts remaining
  logic              done_reg;    // One-cycle completion pulse
  logic [D*4-1:0]    adj;         // Digits after add-three step

  // Add three to each digit of five or more before the shift
  for (genvar i = 0; i < D; i++) begin : g_digit
    assign adj[i*4 +: 4] = (bcd_reg[i*4 +: 4] >= 4'h5) ?
                           4'(bcd_reg[i*4 +: 4] + 4'h3) :
                           bcd_reg[i*4 +: 4];
  end

  assign busy = (state_reg == S_RUN);
  assign done = done_reg;
  assign dec  = bcd_reg;

  ////////////////////////////////////////////////////////////////////////
  // Shift engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      bcd_reg   <= '0;
      bin_reg   <= '0;
      cnt_reg   <= '0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          // Load a fresh value, digits cleared
          if (start) begin
            bcd_reg   <= '0;
            bin_reg   <= bin;
            cnt_reg   <= 6'(W);
            state_reg <= S_RUN;
          end
        end
        S_RUN: begin
          // Shift one binary bit into the digit chain
          {bcd_reg, bin_reg} <= {adj, bin_reg} << 1;
          cnt_reg <= cnt_reg - 6'h01;
          if (cnt_reg == 6'h01) begin
            state_reg <= S_IDLE;
            done_reg  <= 1'b1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule : ser_bin2dec

// ---- hdl/ser_status_top.sv ----
// Purpose: Event status, enable masks, status byte and service request
// Assumes: A parser hands decoded commands and error strobes in sync
// Notes:   Queries answer in packed decimal after a short conversion
//
// Overview of operation
// - Event flags latch; event query returns them
// - Enabled flag rising sets event summary bit
// - Event enable mask set and queried by command
// - Bit0 on completion after all done; bit1 zero
// - Bit2 on read without query or abandon
// - Bit3 on device dependent error
// - Bit4 on execution error
// - Bit5 on undefined or malformed command
// - Bit6 on switch to local control
// - Bit7 set once at power up
// - Questionable parts queried, all read zero
// - Activity condition live, event since read
// - Activity bit0 high while calibrating
// - Service request from enabled bits 2,4,5
// - Mask 1 and 32 make completion request
// - Service request is only unsolicited output
// - Serial poll returns same status byte
// - Query answers are decimal numbers
// - Reading an event part clears it
// - Summary is OR of flag AND enable; activity summary bit7 is OR of events, no enable
// - Event summary sits in status bit 5
// - Status bit6 shows any enabled bit
`timescale 1ns/1ps
module ser_status_top
  import ser_pkg::*;
(
  // Clock and reset
  input  wire logic         CLOCK,
  input  wire logic         RST_B,
  // Decoded commands from the parser
  input  wire logic         CMD_STB,
  input  wire logic [3:0]   CMD_CODE,
  input  wire logic [7:0]   CMD_DATA,
  output logic              CMD_READY,
  // Error and event strobes
  input  wire logic         CMD_ERR_STB,
  input  wire logic         EXEC_ERR_STB,
  input  wire logic         DEV_ERR_STB,
  input  wire logic         LOCAL_STB,
  // Instrument state
  input  wire logic         ALL_DONE,
  input  wire logic         CAL_ACTIVE,
  input  wire logic         ERRQ_NONEMPTY,
  // Query response
  output logic              RESP_VALID,
  output logic [19:0]       RESP_DEC,
  input  wire logic         RESP_READ,
  // Serial poll and service request
  input  wire logic         SPOLL_STB,
  output logic              SPOLL_VALID,
  output logic [7:0]        SPOLL_DATA,
  output logic              SRQ_REQ
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_s1_reg;   // First release stage
  logic rst_n;        // Released reset for the block

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]  esr_reg;          // Event status flags
  logic [7:0]  ese_reg;          // Event status enable mask
  logic [7:0]  sre_reg;          // Service request enable mask
  logic [15:0] oper_cond_reg;    // Live activity condition
  logic [15:0] oper_even_reg;    // Activity events since last read
  logic        opc_pend_reg;     // Completion command waiting
  logic        pon_done_reg;     // Power-on flag already raised
  logic        resp_pend_reg;    // Answer waiting to be fetched
  logic        cmd_ready_reg;    // Parser may present a command
  logic        resp_valid_reg;   // Answer presented
  logic [19:0] resp_dec_reg;     // Answer digits
  logic        spoll_valid_reg;  // Poll byte presented
  logic [7:0]  spoll_data_reg;   // Poll byte
  logic        srq_reg;          // Service request line

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  wire cmd_take   = CMD_STB && cmd_ready_reg;
  wire q_esr      = cmd_take && (CMD_CODE == CMD_ESR_QUERY);
  wire w_ese      = cmd_take && (CMD_CODE == CMD_ESE_SET);
  wire q_ese      = cmd_take && (CMD_CODE == CMD_ESE_QUERY);
  wire q_qcond    = cmd_take && (CMD_CODE == CMD_QUES_COND_Q);
  wire q_qeven    = cmd_take && (CMD_CODE == CMD_QUES_EVEN_Q);
  wire q_ocond    = cmd_take && (CMD_CODE == CMD_OPER_COND_Q);
  wire q_oeven    = cmd_take && (CMD_CODE == CMD_OPER_EVEN_Q);
  wire q_stb      = cmd_take && (CMD_CODE == CMD_STB_QUERY);
  wire w_sre      = cmd_take && (CMD_CODE == CMD_SRE_SET);
  wire q_sre      = cmd_take && (CMD_CODE == CMD_SRE_QUERY);
  wire c_opc      = cmd_take && (CMD_CODE == CMD_OPC);
  // Codes beyond the map count as undefined commands
  wire c_undef    = cmd_take && (CMD_CODE > CMD_OPC);
  wire any_query  = q_esr | q_ese | q_qcond | q_qeven | q_ocond |
                    q_oeven | q_stb | q_sre;

  ////////////////////////////////////////////////////////////////////////
  // Query error detection
  // Reading with nothing prepared, or a new command over an unread answer
  wire read_empty = RESP_READ && !resp_pend_reg;
  wire abandon    = cmd_take && resp_pend_reg && !RESP_READ;

  ////////////////////////////////////////////////////////////////////////
  // Event flag sets and clears
  wire opc_hit    = (opc_pend_reg || c_opc) && ALL_DONE;
  logic [7:0] esr_set;
  assign esr_set[ESR_OPC_BIT]  = opc_hit;
  assign esr_set[ESR_UNUSED]   = 1'b0;
  assign esr_set[ESR_QERR_BIT] = read_empty | abandon;
  assign esr_set[ESR_DDE_BIT]  = DEV_ERR_STB;
  assign esr_set[ESR_EXE_BIT]  = EXEC_ERR_STB;
  assign esr_set[ESR_CME_BIT]  = CMD_ERR_STB | c_undef;
  assign esr_set[ESR_URQ_BIT]  = LOCAL_STB;
  assign esr_set[ESR_PON_BIT]  = !pon_done_reg;

  // Set wins over the read clear so no event is lost
  wire [7:0]  esr_next  = (q_esr ? 8'h00 : esr_reg) | esr_set;
  wire [15:0] oper_rise = CAL_ACTIVE & ~oper_cond_reg[OPER_CAL_BIT] ?
                          16'h0001 : 16'h0000;
  wire [15:0] oper_even_next = (q_oeven ? 16'h0000 : oper_even_reg) |
                               oper_rise;

  ////////////////////////////////////////////////////////////////////////
  // Status byte assembly
  wire esb_w   = |(esr_reg & ese_reg);
  wire oper_w  = |oper_even_reg;
  logic [7:0] stb_low;                                        // Without bit6
  assign stb_low = {oper_w, 1'b0, esb_w, resp_pend_reg, 1'b0,
                    ERRQ_NONEMPTY, 2'b00};
  wire mss_w   = |(stb_low & sre_reg & SRE_WR_MASK);
  wire [7:0] stb_w = stb_low | (mss_w ? 8'h40 : 8'h00);
  wire srq_w   = |(stb_low & sre_reg & SRQ_SRC_MASK);

  ////////////////////////////////////////////////////////////////////////
  // Query answer selection
  logic [15:0] q_val;
  assign q_val = q_esr   ? {8'h00, esr_reg} :
                 q_ese   ? {8'h00, ese_reg} :
                 q_ocond ? oper_cond_reg :
                 q_oeven ? oper_even_reg :
                 q_stb   ? {8'h00, stb_w} :
                 q_sre   ? {8'h00, sre_reg} :
                 QUES_VAL;

  // Decimal conversion of the selected value
  logic        cv_busy;
  logic        cv_done;
  logic [19:0] cv_dec;

  ser_bin2dec #(
    .W (BIN_W),
    .D (DEC_D)
  ) u_dec (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .start (any_query),
    .bin   (q_val),
    .busy  (cv_busy),
    .done  (cv_done),
    .dec   (cv_dec)
  );

  ////////////////////////////////////////////////////////////////////////
  // Flags and masks
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      esr_reg       <= ESR_RST;
      ese_reg       <= ESE_RST;
      sre_reg       <= SRE_RST;
      oper_cond_reg <= OPER_RST;
      oper_even_reg <= OPER_RST;
      opc_pend_reg  <= 1'b0;
      pon_done_reg  <= 1'b0;
    end else begin
      esr_reg       <= esr_next;
      // Masks change only by their set commands
      if (w_ese) ese_reg <= CMD_DATA;
      if (w_sre) sre_reg <= CMD_DATA & SRE_WR_MASK;
      oper_cond_reg <= {15'h0000, CAL_ACTIVE};
      oper_even_reg <= oper_even_next;
      // Completion waits until earlier work drains
      if (opc_hit) opc_pend_reg <= 1'b0;
      else if (c_opc) opc_pend_reg <= 1'b1;
      pon_done_reg  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Response handshake; one query in flight at a time
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready_reg  <= 1'b1;
      resp_pend_reg  <= 1'b0;
      resp_valid_reg <= 1'b0;
      resp_dec_reg   <= '0;
    end else begin
      if (any_query) begin
        cmd_ready_reg  <= 1'b0;
        resp_pend_reg  <= 1'b0;
        resp_valid_reg <= 1'b0;
      end else if (cv_done) begin
        // Answer ready; parser may go on
        cmd_ready_reg  <= 1'b1;
        resp_pend_reg  <= 1'b1;
        resp_valid_reg <= 1'b1;
        resp_dec_reg   <= cv_dec;
      end else if (RESP_READ || abandon) begin
        // Fetched or dropped by a new command
        resp_pend_reg  <= 1'b0;
        resp_valid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial poll and service request line
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      spoll_valid_reg <= 1'b0;
      spoll_data_reg  <= 8'h00;
      srq_reg         <= 1'b0;
    end else begin
      spoll_valid_reg <= SPOLL_STB;
      if (SPOLL_STB) spoll_data_reg <= stb_w;
      srq_reg <= srq_w;
    end
  end

  assign CMD_READY   = cmd_ready_reg;
  assign RESP_VALID  = resp_valid_reg;
  assign RESP_DEC    = resp_dec_reg;
  assign SPOLL_VALID = spoll_valid_reg;
  assign SPOLL_DATA  = spoll_data_reg;
  assign SRQ_REQ     = srq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  property p_unused_zero;
    !esr_reg[ESR_UNUSED] && oper_cond_reg[15:1] == 15'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused status bit set");

  property p_opc_set;
    opc_hit |=> esr_reg[ESR_OPC_BIT];
  endproperty
  a_opc_set: assert property (p_opc_set)
    else $error("completion flag not set");

  property p_qerr;
    read_empty |=> esr_reg[ESR_QERR_BIT];
  endproperty
  a_qerr: assert property (p_qerr)
    else $error("query error flag not set");

  property p_errs;
    DEV_ERR_STB |=> esr_reg[ESR_DDE_BIT];
  endproperty
  a_errs: assert property (p_errs)
    else $error("device error flag not set");

  property p_exe;
    EXEC_ERR_STB |=> esr_reg[ESR_EXE_BIT];
  endproperty
  a_exe: assert property (p_exe)
    else $error("execution error flag not set");

  // Undefined codes count the same as a parser command error
  property p_cme;
    (CMD_ERR_STB || c_undef) |=> esr_reg[ESR_CME_BIT];
  endproperty
  a_cme: assert property (p_cme)
    else $error("command error flag not set");

  property p_urq;
    LOCAL_STB |=> esr_reg[ESR_URQ_BIT];
  endproperty
  a_urq: assert property (p_urq)
    else $error("local control flag not set");

  property p_clear;
    q_esr && esr_set == 8'h00 |=> esr_reg == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("event read did not clear");

  property p_sticky;
    !q_esr |=> (esr_reg & $past(esr_reg)) == $past(esr_reg);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event flag lost");

  property p_srq;
    (esb_w && sre_reg[STB_ESB_BIT]) |=> SRQ_REQ;
  endproperty
  a_srq: assert property (p_srq)
    else $error("service request missing");

  property p_poll;
    SPOLL_STB |=> SPOLL_VALID && SPOLL_DATA == $past(stb_w);
  endproperty
  a_poll: assert property (p_poll)
    else $error("poll byte mismatch");

  property p_cal;
    $rose(CAL_ACTIVE) |=> oper_cond_reg[0] && oper_even_reg[0];
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration not recorded");

  // Ready was high at the taking edge; it drops one cycle later
  property p_answer;
    any_query |=> !CMD_READY ##17 RESP_VALID;
  endproperty
  a_answer: assert property (p_answer)
    else $error("query answer late");

  // No command may slip in while digits are still being built
  property p_busy;
    cv_busy |-> !cmd_ready_reg;
  endproperty
  a_busy: assert property (p_busy)
    else $error("command accepted during conversion");

  c_srq_opc:  cover property (c_opc ##[1:40] SRQ_REQ);
  c_esr_read: cover property (q_esr ##[1:20] RESP_VALID);
  c_poll:     cover property (SRQ_REQ ##1 SPOLL_STB);

endmodule : ser_status_top

// ---- sim/ser_ctrl_model.sv ----
// Purpose: Remote controller model: commands, answer fetch, serial poll
// Assumes: Drives just after rising edges, samples on falling edges
// Notes:   READ_LAG sets how slowly the controller fetches answers
`timescale 1ns/1ps
module ser_ctrl_model #(
  parameter int READ_LAG = 0
) (
  // Clock
  input  wire logic        clk,
  // Command side
  input  wire logic        cmd_ready,
  output logic             cmd_stb,
  output logic [3:0]       cmd_code,
  output logic [7:0]       cmd_data,
  // Answer side
  input  wire logic        resp_valid,
  input  wire logic [19:0] resp_dec,
  output logic             resp_read,
  // Serial poll
  input  wire logic        spoll_valid,
  input  wire logic [7:0]  spoll_data,
  output logic             spoll_stb
);
  ////////////////////////////////////////////////////////////////////////
  // Idle levels at time zero
  initial begin
    cmd_stb   = 1'b0;
    cmd_code  = 4'h0;
    cmd_data  = 8'h00;
    resp_read = 1'b0;
    spoll_stb = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Masks are only ever written through this command path
  task automatic send(input logic [3:0] c, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 64) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    cmd_stb  <= 1'b1;
    cmd_code <= c;
    cmd_data <= d;
    @(posedge clk);
    cmd_stb  <= 1'b0;
    // Released lines show the inverse, never a stale copy
    cmd_code <= ~c;
    cmd_data <= ~d;
  endtask : send

  // One fetch pulse, answer or not
  task automatic pulse_read();
    @(posedge clk);
    resp_read <= 1'b1;
    @(posedge clk);
    resp_read <= 1'b0;
  endtask : pulse_read

  // Wait for the answer, keep its digits, then fetch it
  task automatic fetch(output logic [19:0] v);
    int n;
    n = 0;
    v = 'x;
    while (resp_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (resp_valid === 1'b1) v = resp_dec;
    repeat (READ_LAG) @(negedge clk);
    pulse_read();
  endtask : fetch

  // Serial poll by interface message, no command used
  task automatic poll(output logic [7:0] s);
    @(posedge clk);
    spoll_stb <= 1'b1;
    @(posedge clk);
    spoll_stb <= 1'b0;
    @(negedge clk);
    s = (spoll_valid === 1'b1) ? spoll_data : 8'hxx;
  endtask : poll
endmodule : ser_ctrl_model

// ---- sim/ser_status_top_tb.sv ----
// Purpose: Self-checking bench for the status and event reporting block
// Assumes: Answers are packed decimal digits, digit 0 lowest
// Notes:   Table rows first, then hand-written awkward cases
`timescale 1ns/1ps
module ser_status_top_tb;
  import ser_pkg::*;

  // One table row: optional strobe, command, expected answer
  typedef struct packed {
    logic [2:0]  ev;   // 1 cmd, 2 exec, 3 dev, 4 local
    logic [3:0]  code;
    logic [7:0]  data;
    logic        ask;  // Command yields an answer
    logic [19:0] exp;
  } ser_row_t;

  ////////////////////////////////////////////////////////////////////////
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cmd_stb, cmd_ready, resp_valid, resp_read;
  logic [3:0]  cmd_code;
  logic [7:0]  cmd_data, sb;
  logic        cmd_err = 1'b0, exec_err = 1'b0;
  logic        dev_err = 1'b0, local_sw = 1'b0;
  logic        all_done = 1'b0, cal = 1'b0, errq = 1'b0;
  logic [19:0] resp_dec, got;
  logic        spoll_stb, spoll_valid, srq;
  logic [7:0]  spoll_data;
  int          miscompares = 0;
  int          n_checks = 0;
  ser_row_t    rows [13];

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  ser_status_top i_dut (
    .CLOCK(clk), .RST_B(rst_b),
    .CMD_STB(cmd_stb), .CMD_CODE(cmd_code), .CMD_DATA(cmd_data),
    .CMD_READY(cmd_ready),
    .CMD_ERR_STB(cmd_err), .EXEC_ERR_STB(exec_err),
    .DEV_ERR_STB(dev_err), .LOCAL_STB(local_sw),
    .ALL_DONE(all_done), .CAL_ACTIVE(cal), .ERRQ_NONEMPTY(errq),
    .RESP_VALID(resp_valid), .RESP_DEC(resp_dec), .RESP_READ(resp_read),
    .SPOLL_STB(spoll_stb), .SPOLL_VALID(spoll_valid),
    .SPOLL_DATA(spoll_data), .SRQ_REQ(srq)
  );

  // Slow fetching controller, so answers stand a few cycles
  ser_ctrl_model #(.READ_LAG(3)) i_ctrl (
    .clk(clk), .cmd_ready(cmd_ready), .cmd_stb(cmd_stb),
    .cmd_code(cmd_code), .cmd_data(cmd_data),
    .resp_valid(resp_valid), .resp_dec(resp_dec), .resp_read(resp_read),
    .spoll_valid(spoll_valid), .spoll_data(spoll_data),
    .spoll_stb(spoll_stb)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [19:0] e,
                     input logic [19:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // Query and compare the decimal answer
  task automatic q(input logic [3:0] c, input logic [19:0] e);
    i_ctrl.send(c, 8'h00);
    i_ctrl.fetch(got);
    chk("answer", e, got);
  endtask : q

  // Hold reset ten cycles, then give the synchroniser time
  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : do_reset

  // One-cycle event strobe
  task automatic pulse(input logic [2:0] k);
    @(posedge clk);
    cmd_err  <= (k == 3'd1);
    exec_err <= (k == 3'd2);
    dev_err  <= (k == 3'd3);
    local_sw <= (k == 3'd4);
    @(posedge clk);
    {cmd_err, exec_err, dev_err, local_sw} <= 4'h0;
  endtask : pulse

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{
      '{3'd0, CMD_ESR_QUERY,   8'h00, 1'b1, 20'h0_0128},
      '{3'd0, CMD_ESR_QUERY,   8'h00, 1'b1, 20'h0_0000},
      '{3'd1, CMD_ESR_QUERY,   8'h00, 1'b1, 20'h0_0032},
      '{3'd2, CMD_ESR_QUERY,   8'h00, 1'b1, 20'h0_0016},
      '{3'd3, CMD_ESR_QUERY,   8'h00, 1'b1, 20'h0_0008},
      '{3'd4, CMD_ESR_QUERY,   8'h00, 1'b1, 20'h0_0064},
      '{3'd0, CMD_ESE_SET,     8'hFF, 1'b0, 20'h0_0000},
      '{3'd0, CMD_ESE_QUERY,   8'h00, 1'b1, 20'h0_0255},
      '{3'd0, CMD_QUES_COND_Q, 8'h00, 1'b1, 20'h0_0000},
      '{3'd0, CMD_QUES_EVEN_Q, 8'h00, 1'b1, 20'h0_0000},
      '{3'd0, 4'hB,            8'h00, 1'b0, 20'h0_0000},
      '{3'd0, CMD_ESR_QUERY,   8'h00, 1'b1, 20'h0_0032},
      '{3'd0, CMD_SRE_QUERY,   8'h00, 1'b1, 20'h0_0000}
    };
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].ev != 3'd0) pulse(rows[i].ev);
      i_ctrl.send(rows[i].code, rows[i].data);
      if (rows[i].ask) begin
        i_ctrl.fetch(got);
        chk("row answer", rows[i].exp, got);
      end
    end
    $display("test table done");

    // Completion waits for earlier work, then raises a request
    i_ctrl.send(CMD_ESE_SET, 8'h01);
    i_ctrl.send(CMD_SRE_SET, 8'h20);
    i_ctrl.send(CMD_OPC, 8'h00);
    repeat (4) @(negedge clk);
    chk("srq before done", 20'h0_0000, {19'h0_0000, srq});
    @(posedge clk);
    all_done <= 1'b1;
    repeat (4) @(negedge clk);
    chk("srq after done", 20'h0_0001, {19'h0_0000, srq});
    i_ctrl.poll(sb);
    chk("poll byte", 20'h0_0060, {12'h000, sb});
    q(CMD_ESR_QUERY, 20'h0_0001);
    repeat (3) @(negedge clk);
    chk("srq after read", 20'h0_0000, {19'h0_0000, srq});
    $display("test completion done");

    // Read with nothing pending, then an abandoned answer
    i_ctrl.pulse_read();
    q(CMD_ESR_QUERY, 20'h0_0004);
    i_ctrl.send(CMD_ESE_QUERY, 8'h00);
    // Answer dropped by a mask write; a query would read the old flags
    i_ctrl.send(CMD_ESE_SET, 8'h01);
    q(CMD_ESR_QUERY, 20'h0_0004);
    $display("test query error done");

    // Calibration: live condition, event kept until read
    @(posedge clk);
    cal <= 1'b1;
    q(CMD_OPER_COND_Q, 20'h0_0001);
    q(CMD_OPER_EVEN_Q, 20'h0_0001);
    q(CMD_OPER_EVEN_Q, 20'h0_0000);
    @(posedge clk);
    cal <= 1'b0;
    q(CMD_OPER_COND_Q, 20'h0_0000);
    $display("test calibration done");

    // Error queue bit alone raises the request
    i_ctrl.send(CMD_SRE_SET, 8'h04);
    @(posedge clk);
    errq <= 1'b1;
    repeat (4) @(negedge clk);
    chk("srq queue", 20'h0_0001, {19'h0_0000, srq});
    i_ctrl.poll(sb);
    chk("poll queue", 20'h0_0044, {12'h000, sb});
    @(posedge clk);
    errq <= 1'b0;
    repeat (4) @(negedge clk);
    chk("srq queue off", 20'h0_0000, {19'h0_0000, srq});
    $display("test error queue done");

    // Second reset in mid-run restores power-on state
    do_reset();
    q(CMD_ESR_QUERY, 20'h0_0128);
    q(CMD_SRE_QUERY, 20'h0_0000);
    $display("test reset done");
    test_done();
  end
endmodule : ser_status_top_tb
